// >>> src/asr_params.svh
// Constants of the auxiliary signal router: offsets, reset values, timing.
// Assumes a 100 MHz register clock; included by the package and the router.
// Notes on behaviour
// - Six input pins, three output pins, each assignable
// - Any input pin feeds any input function
// - Any output pin drives any internal event
// - Input defaults: convert, start, stop, update, outstart, gate
// - Output defaults: update, convert, mux switch pulse
// - Scan hold drops at last conversion start
// - One scan start pulse per channel scan
// - Done pulse when a scan ends
// - Header carries five strobes plus shared clock
// - Header lines pulse one sync_clk cycle per event
// - Master drives the common 40 MHz clock
// - One master, three slaves; role sets clock direction
// - 8K configuration queue of channel, gain, offset
// - 8K sample FIFO until host reads
// - 16K waveform buffer for analog outputs
// - Mux pulse 400 ns, 50 ns after convert
// - Gate holds off new scans, current finishes
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
// Register byte offsets
`define ASR_OFS_CTRL    12'h000
`define ASR_OFS_IN_SEL  12'h004
`define ASR_OFS_OUT_SEL 12'h008
`define ASR_OFS_IN_POL  12'h00c
`define ASR_OFS_STATUS  12'h010
`define ASR_OFS_QUEUE   12'h014
`define ASR_OFS_FIFO    12'h018
`define ASR_OFS_WAVE    12'h01c
// Control fields
`define ASR_CTRL_MASTER 0
`define ASR_CTRL_MUXPOL 1
`define ASR_CTRL_HLDPOL 2
`define ASR_CTRL_EXTCNV 3
`define ASR_CTRL_ACQEN  4
// Reset values
`define ASR_RST_CTRL    5'h00
`define ASR_RST_IN_SEL  24'hee5478
`define ASR_RST_OUT_SEL 12'h437
`define ASR_RST_IN_POL  8'h00
// Timing
`define ASR_CLK_NS      10
`define ASR_PULSE_NS    50
`define ASR_MUX_DLY_NS  50
`define ASR_MUX_WID_NS  400
`define ASR_PULSE_CYC   ((`ASR_PULSE_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MUX_DLY_CYC ((`ASR_MUX_DLY_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_MUX_WID_CYC ((`ASR_MUX_WID_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`endif

// >>> src/asr_pkg.sv
// Types shared by the auxiliary signal router and its bench.
// Assumes asr_params.svh is on the include path.
`default_nettype none
package asr_pkg;
  `include "asr_params.svh"
  // Input functions, index into the source select field
  typedef enum logic [2:0] {
    ASR_IN_CONVERT = 3'h0, ASR_IN_ACQ_TB = 3'h1, ASR_IN_START = 3'h2, ASR_IN_STOP = 3'h3,
    ASR_IN_GATE = 3'h4, ASR_IN_OUT_START = 3'h5, ASR_IN_UPDATE = 3'h6, ASR_IN_OUT_TB = 3'h7
  } asr_in_e;
  // Output events selectable per output pin
  typedef enum logic [3:0] {
    ASR_EV_SCAN_START = 4'h0, ASR_EV_SCAN_HOLD = 4'h1, ASR_EV_ACQ_DONE = 4'h2,
    ASR_EV_CONVERT = 4'h3, ASR_EV_MUX_SWITCH = 4'h4, ASR_EV_CTR1 = 4'h5, ASR_EV_CTR2 = 4'h6,
    ASR_EV_UPDATE = 4'h7, ASR_EV_START = 4'h8, ASR_EV_STOP = 4'h9, ASR_EV_GATE = 4'ha,
    ASR_EV_OUT_START = 4'hb
  } asr_ev_e;
  // Scan sequencer
  typedef enum logic [0:0] {ASR_IDLE = 1'b0, ASR_SCAN = 1'b1} asr_scan_e;
  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } asr_apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } asr_apb_rsp_s;
  // Two-way header strobe lines: start, stop, convert, update, output start
  typedef struct packed {
    logic [4:0] dout;
    logic [4:0] oe;
  } asr_link_drv_s;
endpackage : asr_pkg
`default_nettype wire

// >>> src/asr_router.sv
// Auxiliary signal router: pin muxes, scan sequencer, buffers, header link.
// Assumes pclk at 100 MHz and the header clock sync_clk at 40 MHz.
`default_nettype none
`include "asr_params.svh"
module asr_router #(
  parameter int QDEPTH = 8192,   // Configuration queue entries
  parameter int FDEPTH = 8192,   // Sample FIFO entries
  parameter int WDEPTH = 16384,  // Waveform buffer entries
  parameter int DW     = 16      // Queue, sample and waveform word width
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire asr_pkg::asr_apb_req_s apb_req,
  output var  asr_pkg::asr_apb_rsp_s apb_rsp,
  input  wire logic [5:0]            aux_input_pin,
  output logic [2:0]                 aux_output_pin,
  input  wire logic                  pacer_tick,
  input  wire logic                  counter_one_clock,
  input  wire logic                  counter_two_clock,
  input  wire logic                  sample_valid,
  input  wire logic [DW-1:0]         sample_data,
  output logic                       conv_start,
  output logic [DW-1:0]              conv_entry,
  output logic                       acq_timebase_tick,
  output logic                       out_timebase_tick,
  output logic                       out_start_evt,
  output logic [DW-1:0]              wave_data,
  input  wire logic                  sync_clk,
  input  wire logic [4:0]            link_in,
  output var  asr_pkg::asr_link_drv_s link_drv,
  output logic                       sync_clk_oe
);
  import asr_pkg::*;
  localparam int QW = $clog2(QDEPTH);
  localparam int FW = $clog2(FDEPTH);
  localparam int WW = $clog2(WDEPTH);
  localparam logic [2:0] PCYC = 3'(`ASR_PULSE_CYC);
  localparam logic [5:0] MDLY = 6'(`ASR_MUX_DLY_CYC);
  localparam logic [5:0] MWID = 6'(`ASR_MUX_WID_CYC);

  // Register-clock state, one record
  typedef struct packed {
    logic [4:0]    ctrl;       // Role, polarities, convert source, enable
    logic [23:0]   in_sel;     // 3-bit source per input function
    logic [11:0]   out_sel;    // 4-bit event per output pin
    logic [7:0]    in_pol;     // Falling-edge select per input function; inverts the gate level
    logic [5:0]    aux_meta;   // Pin synchroniser, first stage
    logic [5:0]    aux_sync;   // Pin synchroniser, second stage
    logic [5:0]    aux_prev;   // Edge detect history
    logic [4:0]    lnk_meta;
    logic [4:0]    lnk_sync;
    logic [4:0]    lnk_prev;
    logic          run;        // Armed by start trigger
    asr_scan_e     st;
    logic [QW-1:0] q_rd;
    logic [QW:0]   q_cnt;
    logic [FW-1:0] f_wr;
    logic [FW-1:0] f_rd;
    logic [FW:0]   f_cnt;
    logic          f_ovf;
    logic [WW-1:0] w_wr;
    logic [WW-1:0] w_rd;
    logic [WW:0]   w_cnt;
    logic [6:0][2:0] pcnt;     // Stretchers: sstart, done, conv, upd, start, stop, ostart
    logic [5:0]    mux_cnt;
    logic          hold;
    logic [2:0]    aux_out;
    logic [4:0]    lnk_tgl;    // Toggle per outgoing header event
    logic          conv_start;
    logic          acq_tb;
    logic          out_tb;
    logic          out_start;
    asr_apb_rsp_s  rsp;
    logic          wr_seen;    // Any register write since reset
  } asr_state_s;

  asr_state_s s_ff, nxt_s;
  logic [DW-1:0] qmem [QDEPTH];  // Channel, gain, offset per entry
  logic [DW-1:0] fmem [FDEPTH];  // Converted samples
  logic [DW-1:0] wmem [WDEPTH];  // Waveform samples
  logic [DW-1:0] conv_entry_ff;
  logic [DW-1:0] wave_ff;

  // Header link domain
  typedef struct packed {
    logic [4:0] in_meta;
    logic [4:0] in_sync;
    logic [4:0] tgl_meta;
    logic [4:0] tgl_sync;
    logic [4:0] tgl_prev;
    logic       role_meta;
    logic       role_sync;
    asr_link_drv_s drv;
    logic       clk_oe;
  } asr_link_s;
  asr_link_s l_ff, nxt_l;

  // Header bit carrying an input function; bit 3 flags none
  function automatic logic [3:0] link_bit(input logic [2:0] fn);
    case (fn)
      ASR_IN_START:     link_bit = 4'h0;
      ASR_IN_STOP:      link_bit = 4'h1;
      ASR_IN_CONVERT:   link_bit = 4'h2;
      ASR_IN_UPDATE:    link_bit = 4'h3;
      ASR_IN_OUT_START: link_bit = 4'h4;
      default:          link_bit = 4'h8;
    endcase
  endfunction : link_bit

  // Edge of the chosen source for one function; pins 0-5, 6 header, 7 none
  function automatic logic fn_edge(input asr_state_s s, input logic [2:0] fn);
    logic [2:0] src;
    logic [3:0] lb;
    logic       r;
    logic       f;
    src = s.in_sel[fn*3 +: 3];
    lb  = link_bit(fn);
    r   = 1'b0;
    f   = 1'b0;
    if (src < 3'h6) begin
      r = s.aux_sync[src] & ~s.aux_prev[src];
      f = ~s.aux_sync[src] & s.aux_prev[src];
    end else if (src == 3'h6 && !lb[3]) begin
      r = s.lnk_sync[lb[2:0]] & ~s.lnk_prev[lb[2:0]];
      f = ~s.lnk_sync[lb[2:0]] & s.lnk_prev[lb[2:0]];
    end
    fn_edge = s.in_pol[fn] ? f : r;
  endfunction : fn_edge

  // Gate is a level: chosen source, polarity applied
  function automatic logic gate_level(input asr_state_s s);
    logic [2:0] src;
    src = s.in_sel[ASR_IN_GATE*3 +: 3];
    gate_level = (src < 3'h6) ? (s.aux_sync[src] ^ s.in_pol[ASR_IN_GATE]) : 1'b0;
  endfunction : gate_level

  logic        ev_conv_in;
  logic        ev_start;
  logic        ev_stop;
  logic        ev_upd;
  logic        ev_ostart;
  logic        gate;
  logic        conv_fire;
  logic        last_conv;
  logic        mux_act;
  logic [11:0] ev_vec;
  logic        acc_setup;
  logic        wr_acc;
  logic        rd_fifo;

  // Register clock next state
  always_comb begin
    nxt_s = s_ff;
    // Pins pass two flops before any logic reads them
    nxt_s.aux_meta = aux_input_pin;
    nxt_s.aux_sync = s_ff.aux_meta;
    nxt_s.aux_prev = s_ff.aux_sync;
    nxt_s.lnk_meta = l_ff.in_sync;
    nxt_s.lnk_sync = s_ff.lnk_meta;
    nxt_s.lnk_prev = s_ff.lnk_sync;
    // Edges rather than muxed levels, so a reselect makes no false edge
    ev_conv_in = fn_edge(s_ff, ASR_IN_CONVERT);
    ev_start   = fn_edge(s_ff, ASR_IN_START);
    ev_stop    = fn_edge(s_ff, ASR_IN_STOP);
    ev_upd     = fn_edge(s_ff, ASR_IN_UPDATE);
    ev_ostart  = fn_edge(s_ff, ASR_IN_OUT_START);
    gate       = gate_level(s_ff);
    nxt_s.acq_tb    = fn_edge(s_ff, ASR_IN_ACQ_TB);
    nxt_s.out_tb    = fn_edge(s_ff, ASR_IN_OUT_TB);
    nxt_s.out_start = ev_ostart;
    // Arming
    if (!s_ff.ctrl[`ASR_CTRL_ACQEN]) begin
      nxt_s.run = 1'b0;
    end else if (ev_start) begin
      nxt_s.run = 1'b1;
    end
    // Scan sequencer; gate only blocks a new scan, never a running one
    last_conv = ({1'b0, s_ff.q_rd} + 1'b1) >= s_ff.q_cnt;
    conv_fire = (s_ff.ctrl[`ASR_CTRL_EXTCNV] ? ev_conv_in : pacer_tick)
                && (s_ff.st == ASR_SCAN || (s_ff.run && !gate));
    nxt_s.conv_start = conv_fire;
    // Count every pulse down first, so a reload below always wins
    for (int i = 0; i < 7; i++) begin
      if (s_ff.pcnt[i] != 3'h0) begin
        nxt_s.pcnt[i] = s_ff.pcnt[i] - 1'b1;
      end
    end
    if (conv_fire) begin
      nxt_s.pcnt[2] = PCYC;
      if (s_ff.st == ASR_IDLE) begin
        nxt_s.pcnt[0] = PCYC;
      end
      if (last_conv) begin
        nxt_s.st   = ASR_IDLE;
        nxt_s.q_rd = '0;
        nxt_s.hold = 1'b0;
        nxt_s.pcnt[1] = PCYC;
      end else begin
        nxt_s.st   = ASR_SCAN;
        nxt_s.q_rd = s_ff.q_rd + 1'b1;
        nxt_s.hold = 1'b1;
      end
    end
    if (ev_upd)    nxt_s.pcnt[3] = PCYC;
    if (ev_start)  nxt_s.pcnt[4] = PCYC;
    if (ev_stop)   nxt_s.pcnt[5] = PCYC;
    if (ev_ostart) nxt_s.pcnt[6] = PCYC;
    // Mux switch: delay then width, restarted by each convert
    if (conv_fire) begin
      nxt_s.mux_cnt = MDLY + MWID;
    end else if (s_ff.mux_cnt != 6'h0) begin
      nxt_s.mux_cnt = s_ff.mux_cnt - 1'b1;
    end
    mux_act = (s_ff.mux_cnt != 6'h0) && (s_ff.mux_cnt <= MWID);
    // Event vector for the output muxes
    ev_vec = '0;
    ev_vec[ASR_EV_SCAN_START] = s_ff.pcnt[0] != 3'h0;
    ev_vec[ASR_EV_SCAN_HOLD]  = s_ff.hold ^ s_ff.ctrl[`ASR_CTRL_HLDPOL];
    ev_vec[ASR_EV_ACQ_DONE]   = s_ff.pcnt[1] != 3'h0;
    ev_vec[ASR_EV_CONVERT]    = s_ff.pcnt[2] != 3'h0;
    ev_vec[ASR_EV_MUX_SWITCH] = mux_act ^ s_ff.ctrl[`ASR_CTRL_MUXPOL];
    ev_vec[ASR_EV_CTR1]       = counter_one_clock;
    ev_vec[ASR_EV_CTR2]       = counter_two_clock;
    ev_vec[ASR_EV_UPDATE]     = s_ff.pcnt[3] != 3'h0;
    ev_vec[ASR_EV_START]      = s_ff.pcnt[4] != 3'h0;
    ev_vec[ASR_EV_STOP]       = s_ff.pcnt[5] != 3'h0;
    ev_vec[ASR_EV_GATE]       = gate;
    ev_vec[ASR_EV_OUT_START]  = s_ff.pcnt[6] != 3'h0;
    for (int p = 0; p < 3; p++) begin
      nxt_s.aux_out[p] = (s_ff.out_sel[p*4 +: 4] < 4'hc) ?
                         ev_vec[s_ff.out_sel[p*4 +: 4]] : 1'b0;
    end
    // Header events leave as toggles; the link side turns them into pulses
    nxt_s.lnk_tgl = s_ff.lnk_tgl ^ {ev_ostart, ev_upd, conv_fire, ev_stop, ev_start};
    // Sample FIFO fill; a full FIFO drops the sample and flags it
    rd_fifo = 1'b0;
    // APB: answer decided in setup, presented in the access cycle
    acc_setup = apb_req.psel && !apb_req.penable;
    wr_acc    = apb_req.psel && apb_req.penable && apb_req.pwrite && s_ff.rsp.pready;
    nxt_s.rsp.pready = acc_setup;
    if (acc_setup) begin
      nxt_s.rsp.pslverr = 1'b0;
      nxt_s.rsp.prdata  = '0;
      case (apb_req.paddr)
        `ASR_OFS_CTRL:    nxt_s.rsp.prdata = 32'(s_ff.ctrl);
        `ASR_OFS_IN_SEL:  nxt_s.rsp.prdata = 32'(s_ff.in_sel);
        `ASR_OFS_OUT_SEL: nxt_s.rsp.prdata = 32'(s_ff.out_sel);
        `ASR_OFS_IN_POL:  nxt_s.rsp.prdata = 32'(s_ff.in_pol);
        `ASR_OFS_STATUS:  nxt_s.rsp.prdata = {8'h00, 15'(s_ff.f_cnt), s_ff.f_ovf,
                                              4'h0, s_ff.run, gate, s_ff.hold, s_ff.st};
        `ASR_OFS_QUEUE:   nxt_s.rsp.prdata = 32'(s_ff.q_cnt);
        `ASR_OFS_FIFO: begin
          nxt_s.rsp.prdata = (s_ff.f_cnt != '0) ? 32'(fmem[s_ff.f_rd]) : 32'h0;
          rd_fifo = !apb_req.pwrite && s_ff.f_cnt != '0;
        end
        `ASR_OFS_WAVE:    nxt_s.rsp.prdata = 32'(s_ff.w_cnt);
        default:          nxt_s.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr_acc && !s_ff.rsp.pslverr) begin
      nxt_s.wr_seen = 1'b1;
      case (apb_req.paddr)
        `ASR_OFS_CTRL:    nxt_s.ctrl    = apb_req.pwdata[4:0];
        `ASR_OFS_IN_SEL:  nxt_s.in_sel  = apb_req.pwdata[23:0];
        `ASR_OFS_OUT_SEL: nxt_s.out_sel = apb_req.pwdata[11:0];
        `ASR_OFS_IN_POL:  nxt_s.in_pol  = apb_req.pwdata[7:0];
        `ASR_OFS_STATUS: begin
          if (apb_req.pwdata[0]) nxt_s.f_ovf = 1'b0;
          if (apb_req.pwdata[1] && s_ff.st == ASR_IDLE) nxt_s.q_cnt = '0;
        end
        `ASR_OFS_QUEUE: begin
          if (s_ff.q_cnt < (QW+1)'(QDEPTH)) nxt_s.q_cnt = s_ff.q_cnt + 1'b1;
        end
        `ASR_OFS_WAVE: begin
          if (s_ff.w_cnt < (WW+1)'(WDEPTH)) begin
            nxt_s.w_wr = s_ff.w_wr + 1'b1;
          end
        end
        default: ;
      endcase
    end
    // FIFO counters; a pop marked in setup lands with the access
    if (sample_valid && s_ff.f_cnt == (FW+1)'(FDEPTH)) begin
      nxt_s.f_ovf = 1'b1;  // Set wins over a same-cycle clear
    end
    nxt_s.f_wr  = s_ff.f_wr + (FW)'(sample_valid && s_ff.f_cnt < (FW+1)'(FDEPTH));
    nxt_s.f_rd  = s_ff.f_rd + (FW)'(rd_fifo);
    nxt_s.f_cnt = s_ff.f_cnt + (FW+1)'(sample_valid && s_ff.f_cnt < (FW+1)'(FDEPTH))
                  - (FW+1)'(rd_fifo);
    // Waveform buffer drains one word per update strobe
    nxt_s.w_rd  = s_ff.w_rd + (WW)'(ev_upd && s_ff.w_cnt != '0);
    nxt_s.w_cnt = s_ff.w_cnt + (WW+1)'(nxt_s.w_wr != s_ff.w_wr)
                  - (WW+1)'(ev_upd && s_ff.w_cnt != '0);
  end

  // Register clock state; selections load their defaults here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff         <= '0;
      s_ff.ctrl    <= `ASR_RST_CTRL;
      s_ff.in_sel  <= `ASR_RST_IN_SEL;
      s_ff.out_sel <= `ASR_RST_OUT_SEL;
      s_ff.in_pol  <= `ASR_RST_IN_POL;
      s_ff.st      <= ASR_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Buffer memories, no reset so they map onto RAM
  always_ff @(posedge pclk) begin
    if (wr_acc && apb_req.paddr == `ASR_OFS_QUEUE && s_ff.q_cnt < (QW+1)'(QDEPTH)) begin
      qmem[s_ff.q_cnt[QW-1:0]] <= apb_req.pwdata[DW-1:0];
    end
    if (wr_acc && apb_req.paddr == `ASR_OFS_WAVE && s_ff.w_cnt < (WW+1)'(WDEPTH)) begin
      wmem[s_ff.w_wr] <= apb_req.pwdata[DW-1:0];
    end
    if (sample_valid && s_ff.f_cnt < (FW+1)'(FDEPTH)) begin
      fmem[s_ff.f_wr] <= sample_data;
    end
  end

  // Entry and waveform outputs, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_entry_ff <= '0;
      wave_ff       <= '0;
    end else begin
      if (conv_fire) conv_entry_ff <= qmem[s_ff.q_rd];
      if (ev_upd && s_ff.w_cnt != '0) wave_ff <= wmem[s_ff.w_rd];
    end
  end

  // Header link side: strobes in and out, clock direction by role
  always_comb begin
    nxt_l           = l_ff;
    nxt_l.in_meta   = link_in;
    nxt_l.in_sync   = l_ff.in_meta;
    nxt_l.tgl_meta  = s_ff.lnk_tgl;
    nxt_l.tgl_sync  = l_ff.tgl_meta;
    nxt_l.tgl_prev  = l_ff.tgl_sync;
    nxt_l.role_meta = s_ff.ctrl[`ASR_CTRL_MASTER];
    nxt_l.role_sync = l_ff.role_meta;
    // Only a master drives the strobes and the shared clock
    nxt_l.drv.dout  = l_ff.tgl_sync ^ l_ff.tgl_prev;
    nxt_l.drv.oe    = {5{l_ff.role_sync}};
    nxt_l.clk_oe    = l_ff.role_sync;
  end

  always_ff @(posedge sync_clk or negedge presetn) begin
    if (!presetn) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // Outputs straight from flops
  assign apb_rsp           = s_ff.rsp;
  assign aux_output_pin    = s_ff.aux_out;
  assign conv_start        = s_ff.conv_start;
  assign conv_entry        = conv_entry_ff;
  assign acq_timebase_tick = s_ff.acq_tb;
  assign out_timebase_tick = s_ff.out_tb;
  assign out_start_evt     = s_ff.out_start;
  assign wave_data         = wave_ff;
  assign link_drv          = l_ff.drv;
  assign sync_clk_oe       = l_ff.clk_oe;

  // Checks
  sequence mux_quiet_then_on;
    !mux_act [*5] ##1 mux_act;
  endsequence
  sequence sstart_wide;
    (s_ff.pcnt[0] != 3'h0) [*5] ##1 (s_ff.pcnt[0] == 3'h0);
  endsequence

  chk_in_default: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ff.wr_seen |-> s_ff.in_sel == `ASR_RST_IN_SEL) else $error("input default lost");
  chk_out_default: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ff.wr_seen |-> s_ff.out_sel == `ASR_RST_OUT_SEL) else $error("output default lost");
  chk_mux_delay: assert property (@(posedge pclk) disable iff (!presetn)
    conv_fire |=> (!mux_act) [*5]) else $error("mux delay wrong");
  chk_mux_start: assert property (@(posedge pclk) disable iff (!presetn)
    conv_fire ##1 (!conv_fire) [*6] |-> mux_act && !$past(mux_act, 1))
    else $error("mux pulse not 50 ns after convert");
  chk_mux_seq: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_fire && s_ff.mux_cnt == 6'h0) |=> mux_quiet_then_on)
    else $error("mux pulse early");
  chk_scan_start: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_fire && s_ff.st == ASR_IDLE) |=> sstart_wide) else $error("scan start width");
  chk_hold_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_fire && last_conv) |=> !s_ff.hold && s_ff.st == ASR_IDLE)
    else $error("hold not dropped at last convert");
  chk_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.st == ASR_IDLE && gate) |=> s_ff.st == ASR_IDLE) else $error("scan under gate");
  chk_done_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_fire && last_conv) |=> (s_ff.pcnt[1] != 3'h0) [*5])
    else $error("done pulse short");
  chk_fifo_bound: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.f_cnt <= (FW+1)'(FDEPTH) && $rose(s_ff.f_ovf) |-> $past(s_ff.f_cnt) == (FW+1)'(FDEPTH))
    else $error("fifo overflow flag wrong");
  chk_link_role: assert property (@(posedge sync_clk) disable iff (!presetn)
    l_ff.drv.oe != 5'h00 |-> l_ff.clk_oe) else $error("strobes driven as slave");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && !apb_req.penable) |=> s_ff.rsp.pready ##1 !s_ff.rsp.pready)
    else $error("apb ready timing");
endmodule : asr_router
`default_nettype wire

// >>> tb/asr_far_board.sv
// Far-side board model: a slave board pulsing the header strobe lines.
// Assumes the bench raises one request bit at a time, in the pclk domain.
`default_nettype none
module asr_far_board (
  input  wire logic       sync_clk, // Shared time base, from the master
  input  wire logic [4:0] req,      // Bench request per strobe line
  output wire logic [4:0] link_in   // Strobe levels towards the router
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines idle low; a slave never drives the shared clock back
  logic [4:0] lines = 5'h00;
  // Requests launched on the common clock, like a real board
  always @(posedge sync_clk) begin
    lines <= req;
  end
  assign link_in = lines;
endmodule : asr_far_board
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the auxiliary signal router.
// Assumes asr_pkg is compiled first; design holds its own assertions.
`default_nettype none
module testbench;
  import asr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          pclk = 0, sync_clk = 0, presetn = 0, pacer = 0, c1 = 0, seen = 0;
  logic          c2 = 0, sv = 0, cs;  // Counter two, sample strobe, convert pulse
  logic [15:0]   sd = '0, ce, wd;     // Sample in, queue entry and waveform out
  asr_apb_req_s  req = '0;        // Register bus request
  asr_apb_rsp_s  rsp;             // Register bus answer
  logic [5:0]    pins = '0;       // Connector inputs
  logic [2:0]    aout;            // Connector outputs
  logic [4:0]    lreq = '0, lin;  // Far board requests and lines
  asr_link_drv_s ldrv;            // Header drive
  logic          oe;              // Clock direction
  logic [7:0]    obs;             // Watched outputs
  logic [31:0]   rd;              // Last read data
  int            errors = 0, tests_run = 0, n, ncs = 0;
  assign obs = {ldrv.dout, aout};
  // Clocks never share a rising edge: 10 ns against 64 ns
  always #5 pclk = ~pclk;
  always #32 sync_clk = ~sync_clk;
  // Header convert strobe seen while driving
  always @(posedge pclk) if (ldrv.dout[2] === 1'b1 && ldrv.oe[2] === 1'b1) seen <= 1'b1;
  // Conversions seen on the convert pulse output
  always @(posedge pclk) if (cs === 1'b1) ncs <= ncs + 1;
  asr_router #(.QDEPTH(16), .FDEPTH(16), .WDEPTH(16), .DW(16)) dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .aux_input_pin(pins), .aux_output_pin(aout), .pacer_tick(pacer),
    .counter_one_clock(c1), .counter_two_clock(c2), .sample_valid(sv),
    .sample_data(sd), .conv_start(cs), .conv_entry(ce), .acq_timebase_tick(),
    .out_timebase_tick(), .out_start_evt(), .wave_data(wd), .sync_clk(sync_clk),
    .link_in(lin), .link_drv(ldrv), .sync_clk_oe(oe));
  asr_far_board far (.sync_clk(sync_clk), .req(lreq), .link_in(lin));
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; held until pready is sampled high, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    if (k == 20) begin
      errors++;
      summarize();
    end
    req <= '0;
    @(posedge pclk);
  endtask : apb
  // Bounded wait for a watched output to reach a level
  task automatic wait_obs(input int i, input logic v);
    int k;
    for (k = 0; k < 300 && obs[i] !== v; k++) @(posedge pclk);
    if (k == 300) begin
      errors++;
      summarize();
    end
  endtask : wait_obs
  // Width of the next pulse on a watched output, in pclk cycles
  task automatic pulse_len(input int i, input int exp);
    wait_obs(i, 1'b1);
    for (n = 0; n < 100 && obs[i] === 1'b1; n++) @(posedge pclk);
    chk(n, exp);
  endtask : pulse_len
  // Rising edge on an input pin, after a settled low level
  task automatic rise(input int b);
    pins[b] <= 1'b0;
    repeat (4) @(posedge pclk);
    pins[b] <= 1'b1;
  endtask : rise
  initial begin
    // Three register clocks; the link flops reset asynchronously
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); chk(rd, 32'h0);
    apb(0, 12'h004, 0); chk(rd, 32'h00ee5478);
    apb(0, 12'h008, 0); chk(rd, 32'h437);
    apb(0, 12'h020, 0); chk(rd, 32'h0); chk(rsp.pslverr, 1'b1);
    rise(3); pulse_len(0, 5);
    apb(1, 12'h000, 32'h19);
    rise(1); rise(0);
    pulse_len(1, 5); chk(aout[2], 1'b1);
    pulse_len(2, 40);
    repeat (30) @(posedge pclk);
    chk(oe, 1'b1); chk(seen, 1'b1);
    apb(1, 12'h000, 32'h1b); repeat (8) @(posedge pclk); chk(aout[2], 1'b1);
    // Scan of two entries: start, hold, done on the three pins
    apb(1, 12'h000, 32'h18); apb(1, 12'h008, 32'h210);
    apb(1, 12'h014, 32'h1); apb(1, 12'h014, 32'h2);
    rise(1); rise(0); pulse_len(0, 5); chk(aout[1], 1'b1);
    chk(ce, 16'h0001);
    rise(0); pulse_len(2, 5); chk(aout[1], 1'b0);
    chk(ce, 16'h0002);
    // Gate closed: a convert starts no scan
    pins <= 6'h20; repeat (4) @(posedge pclk); pins[0] <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      if (aout[0] !== 1'b0) n++;
    end
    chk(n, 0);
    pins <= '0;
    // Start trigger from the header, counter clock on pin 2
    apb(1, 12'h004, 32'h00ee55b8); apb(1, 12'h008, 32'h568);
    lreq <= 5'h01; repeat (10) @(posedge pclk); lreq <= 5'h00;
    pulse_len(0, 5);
    {c1, c2} <= 2'b10; repeat (3) @(posedge pclk); chk(aout[2:1], 2'b10);
    {c1, c2} <= 2'b01; repeat (3) @(posedge pclk); chk(aout[2:1], 2'b01);
    // Sample FIFO: seventeen pushes into sixteen places overflow it
    sv <= 1'b1;
    for (n = 0; n < 17; n++) begin
      sd <= 16'h0100 + 16'(n);
      @(posedge pclk);
    end
    sv <= 1'b0;
    apb(0, 12'h010, 0); chk(rd, 32'h00002108);
    apb(0, 12'h018, 0); chk(rd, 32'h00000100);
    apb(1, 12'h01c, 32'h5a); rise(3); repeat (5) @(posedge pclk);
    chk(wd, 16'h005a);
    chk(ncs, 3);
    summarize();
  end
endmodule : testbench
`default_nettype wire
